// >>> core/ssea_core.sv
// Speech spectral energy analyzer: windowed transforms and energies
// Behaviour
// - Two 256-point transforms per frame, windows overlapping by half.
// - Window centres sit 96 and 224 samples after frame start; the core centres them 128 and 256 samples past base_reg.
// - Sine window of length 256, only its half table is stored.
// - Second analysis uses the same signal offset by 128 samples.
// - Transform covers bins 0 to 128; DC and 6400 Hz dropped later.
// - Twenty bands over 0-6400 Hz at 50 Hz, widths 2 to 21 bins.
// - Band start bins follow the fixed list from bin 1 to 107.
// - Band energy is bin power sum over count times 128 squared.
// - Bin energy for bins 0-127 is four times power over 65536.
// - Frame energy per analysis is the sum of band energies.
// - Total energy in dB is ten log of half both frame energies.
// - Power spectrum is half the sum of both analyses' bin energies.
// - Narrowband input keeps only bands 1 to 16 in the outputs.
// - Relative energy is total dB minus long-term active energy.
// - Bandwidth detection only for input rates above 8 kHz.
// - Four bandwidth classes: narrow, wide, superwide and full band.
// - Detector uses filterbank energies, or a DCT in legacy mode.
module ssea_core (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic signed [ssea_pkg::SAMPLE_W-1:0] sample_in,
    input wire logic sample_valid_in,
    output logic sample_ready_out,
    input wire logic narrowband_in,
    input wire logic signed [ssea_pkg::DB_W-1:0] long_term_energy_in,
    input wire logic [1:0] input_rate_in,
    input wire logic legacy_interop_mode_in,
    input wire logic [1:0] detected_bw_in,
    input wire logic [7:0] bin_sel_in,
    input wire logic [5:0] band_sel_in,
    output logic [ssea_pkg::EN_W-1:0] bin_energy_out,
    output logic [ssea_pkg::EN_W-1:0] power_spectrum_out,
    output logic [ssea_pkg::EN_W-1:0] band_avg_energy_out,
    output logic signed [ssea_pkg::DB_W-1:0] total_energy_db_out,
    output logic signed [ssea_pkg::DB_W-1:0] rel_energy_out,
    output logic results_valid_out,
    output logic done_out,
    output logic bw_detect_enable_out,
    output logic detector_uses_dct_out,
    output logic [1:0] operating_bw_out
);
    localparam int AW = ssea_pkg::MEM_AW;

    // Quarter-wave lookup of sin(2*pi*m/256)
    function automatic logic signed [17:0] sin_q(input logic [7:0] m);
        logic [7:0] i;
        logic signed [17:0] v;
        i = m[6] ? 8'h80 - {1'b0, m[5:0], 1'b0} : {1'b0, m[5:0], 1'b0};
        v = ssea_pkg::SIN_TAB[i];
        return m[7] ? -v : v;
    endfunction

    // Window w(n) = sin(pi*n/256) folded onto the stored half
    function automatic logic signed [17:0] win_coef(input logic [7:0] n);
        logic [7:0] i;
        i = n[7] ? 8'(9'h100 - {1'b0, n}) : n;
        return ssea_pkg::SIN_TAB[i];
    endfunction

    // Log2 in Q8: leading one position with a linear mantissa
    function automatic logic [13:0] log2_q8(input logic [47:0] x);
        logic [5:0] p;
        logic [47:0] norm;
        p = 6'h00;
        for (int i = 0; i < 48; i++) begin
            if (x[i]) begin
                p = 6'(i);
            end
        end
        norm = x << (6'h2f - p);
        return {p, norm[46:39]};
    endfunction

    ssea_pkg::ssea_state_type state_reg, state_next;
    logic signed [ssea_pkg::SAMPLE_W-1:0] smem [0:511];
    logic [ssea_pkg::EN_W-1:0] bemem [0:255];
    logic [ssea_pkg::EN_W-1:0] psmem [0:127];
    logic [ssea_pkg::EN_W-1:0] bmem [0:39];
    logic signed [ssea_pkg::SAMPLE_W-1:0] buf_reg [0:1];
    logic signed [ssea_pkg::SAMPLE_W-1:0] buf_next [0:1];
    logic buf_wp_reg, buf_wp_next, buf_rp_reg, buf_rp_next;
    logic [1:0] buf_cnt_reg, buf_cnt_next;
    logic ready_reg, ready_next;
    logic [AW-1:0] wr_ptr_reg, wr_ptr_next, base_reg, base_next;
    logic [AW-1:0] fill_cnt_reg, fill_cnt_next, need_reg, need_next;
    logic ana_reg, ana_next;
    logic [7:0] k_reg, k_next, n_reg, n_next;
    logic [4:0] b_reg, b_next;
    logic signed [ssea_pkg::ACC_W-1:0] re_reg, re_next, im_reg, im_next;
    logic [ssea_pkg::BSUM_W-1:0] bsum_reg, bsum_next;
    logic [ssea_pkg::SUM_W-1:0] fsum_reg, fsum_next;
    logic valid_reg, valid_next, done_reg, done_next;
    logic signed [ssea_pkg::DB_W-1:0] db_reg, db_next, rel_reg, rel_next;
    logic [ssea_pkg::EN_W-1:0] bin_o_reg, bin_o_next, ps_o_reg, ps_o_next;
    logic [ssea_pkg::EN_W-1:0] band_o_reg, band_o_next;
    logic bwdet_reg, bwdet_next, dct_reg, dct_next;
    logic [1:0] opbw_reg, opbw_next;
    logic s_we, be_we, ps_we, b_we;
    logic [AW-1:0] s_wa, rd_addr;
    logic [7:0] be_wa;
    logic [5:0] b_wa;
    logic [ssea_pkg::EN_W-1:0] ebin, band_e, ps_wd, b_wd;
    logic signed [ssea_pkg::SAMPLE_W-1:0] s_rd;
    logic signed [33:0] prod_w;
    logic signed [17:0] wx;
    logic signed [35:0] prod_c, prod_s;
    logic [15:0] kn;
    logic signed [51:0] sq_re, sq_im;
    logic [ssea_pkg::MAG_W-1:0] mag;
    logic [ssea_pkg::BSUM_W-1:0] bs_tot;
    logic [58:0] bprod;
    logic [44:0] ps_sum;
    logic [13:0] lg;
    logic [23:0] db_prod;
    logic accept, drain, in_band, band_end, incl;

    always_comb begin
        state_next = state_reg;
        buf_next = buf_reg;
        buf_wp_next = buf_wp_reg;
        buf_rp_next = buf_rp_reg;
        wr_ptr_next = wr_ptr_reg;
        base_next = base_reg;
        fill_cnt_next = fill_cnt_reg;
        need_next = need_reg;
        ana_next = ana_reg;
        k_next = k_reg;
        n_next = n_reg;
        b_next = b_reg;
        re_next = re_reg;
        im_next = im_reg;
        bsum_next = bsum_reg;
        fsum_next = fsum_reg;
        valid_next = valid_reg;
        done_next = 1'b0;
        db_next = db_reg;
        rel_next = rel_reg;
        s_we = 1'b0;
        be_we = 1'b0;
        ps_we = 1'b0;
        b_we = 1'b0;
        s_wa = wr_ptr_reg;
        // Two-entry buffer stalls upstream while the transforms run
        accept = sample_valid_in && ready_reg;
        drain = (buf_cnt_reg != 2'h0) && (state_reg == ssea_pkg::ST_FILL);
        if (accept) begin
            buf_next[buf_wp_reg] = sample_in;
            buf_wp_next = !buf_wp_reg;
        end
        buf_cnt_next = buf_cnt_reg + {1'b0, accept} - {1'b0, drain};
        ready_next = (buf_cnt_next != 2'h2);
        // Analysis 1 reads the same history shifted by half a transform
        rd_addr = base_reg + {1'b0, n_reg}
            + (ana_reg ? 9'(ssea_pkg::CENTRE_STEP) : 9'h000);
        s_rd = smem[rd_addr];
        prod_w = s_rd * win_coef(n_reg);
        wx = prod_w[32:15];
        kn = k_reg * n_reg;
        prod_c = wx * sin_q(kn[7:0] + 8'h40) + 36'sh4000;
        prod_s = wx * sin_q(kn[7:0]) + 36'sh4000;
        sq_re = re_reg * re_reg;
        sq_im = im_reg * im_reg;
        mag = sq_re + sq_im;
        ebin = ssea_pkg::EN_W'(mag >> ssea_pkg::BIN_SHIFT);
        bs_tot = bsum_reg + ssea_pkg::BSUM_W'(mag);
        in_band = (k_reg != 8'h00) && (k_reg < ssea_pkg::LAST_BIN);
        band_end = in_band && (k_reg ==
            ssea_pkg::BAND_START[b_reg + 5'h01] - 8'h01);
        bprod = (bs_tot >> ssea_pkg::BAND_SHIFT)
            * ssea_pkg::RECIP[b_reg] + 59'h8000;
        incl = !narrowband_in || ((b_reg >= ssea_pkg::NB_FIRST_BAND)
            && (b_reg <= ssea_pkg::NB_LAST_BAND));
        band_e = incl ? ssea_pkg::EN_W'(bprod >> ssea_pkg::RECIP_Q)
            : '0;
        be_wa = {ana_reg, k_reg[6:0]};
        ps_sum = {1'b0, bemem[{1'b0, k_reg[6:0]}]} + {1'b0, ebin};
        ps_wd = ps_sum[44:1];
        b_wa = 6'(b_reg) + (ana_reg ? 6'(ssea_pkg::NUM_BANDS) : 6'h00);
        b_wd = band_e;
        lg = log2_q8({1'b0, fsum_reg[ssea_pkg::SUM_W-1:1]});
        db_prod = lg * ssea_pkg::DB_PER_OCT;
        case (state_reg)
            ssea_pkg::ST_FILL: begin
                if (drain) begin
                    s_we = 1'b1;
                    buf_rp_next = !buf_rp_reg;
                    wr_ptr_next = wr_ptr_reg + 9'h001;
                    fill_cnt_next = fill_cnt_reg + 9'h001;
                    if (fill_cnt_next == need_reg) begin
                        state_next = ssea_pkg::ST_MAC;
                        fill_cnt_next = 9'h000;
                        valid_next = 1'b0;
                        ana_next = 1'b0;
                        k_next = 8'h00;
                        n_next = 8'h00;
                        b_next = 5'h00;
                        re_next = '0;
                        im_next = '0;
                        bsum_next = '0;
                        fsum_next = '0;
                    end
                end
            end
            ssea_pkg::ST_MAC: begin
                re_next = re_reg + ssea_pkg::ACC_W'(prod_c >>> 15);
                im_next = im_reg - ssea_pkg::ACC_W'(prod_s >>> 15);
                n_next = n_reg + 8'h01;
                if (n_reg == 8'hff) begin
                    state_next = ssea_pkg::ST_BIN;
                end
            end
            ssea_pkg::ST_BIN: begin
                be_we = !k_reg[7];
                ps_we = ana_reg && !k_reg[7];
                if (in_band) begin
                    bsum_next = bs_tot;
                end
                if (band_end) begin
                    b_we = 1'b1;
                    fsum_next = fsum_reg
                        + ssea_pkg::SUM_W'(band_e);
                    bsum_next = '0;
                    b_next = b_reg + 5'h01;
                end
                re_next = '0;
                im_next = '0;
                state_next = ssea_pkg::ST_MAC;
                if (k_reg == ssea_pkg::LAST_BIN) begin
                    k_next = 8'h00;
                    b_next = 5'h00;
                    ana_next = 1'b1;
                    if (ana_reg) begin
                        state_next = ssea_pkg::ST_FIN;
                    end
                end else begin
                    k_next = k_reg + 8'h01;
                end
            end
            ssea_pkg::ST_FIN: begin
                db_next = ssea_pkg::DB_W'(db_prod >> ssea_pkg::DB_SHIFT);
                rel_next = db_next - long_term_energy_in;
                done_next = 1'b1;
                valid_next = 1'b1;
                base_next = base_reg + 9'(ssea_pkg::FRAME_LEN);
                need_next = 9'(ssea_pkg::FRAME_LEN);
                state_next = ssea_pkg::ST_FILL;
            end
            default: begin
                state_next = ssea_pkg::ST_FILL;
            end
        endcase
        // Stored results read as zero while a frame is being computed
        bin_o_next = valid_next ? bemem[bin_sel_in] : '0;
        ps_o_next = valid_next ? psmem[bin_sel_in[6:0]] : '0;
        band_o_next = (valid_next && (band_sel_in < 6'h28))
            ? bmem[band_sel_in] : '0;
        bwdet_next = (input_rate_in != ssea_pkg::RATE_8K);
        dct_next = legacy_interop_mode_in;
        // Detected class is capped by what the input rate can carry
        opbw_next = (!bwdet_next || (detected_bw_in > input_rate_in))
            ? input_rate_in : detected_bw_in;
    end

    always_ff @(posedge clock_in) begin
        if (s_we) begin
            smem[s_wa] <= buf_reg[buf_rp_reg];
        end
        if (be_we) begin
            bemem[be_wa] <= ebin;
        end
        if (ps_we) begin
            psmem[k_reg[6:0]] <= ps_wd;
        end
        if (b_we) begin
            bmem[b_wa] <= b_wd;
        end
        buf_reg <= buf_next;
        re_reg <= re_next;
        im_reg <= im_next;
        bsum_reg <= bsum_next;
        fsum_reg <= fsum_next;
        k_reg <= k_next;
        n_reg <= n_next;
        b_reg <= b_next;
        ana_reg <= ana_next;
        if (rst_in) begin
            state_reg <= ssea_pkg::ST_FILL;
            buf_wp_reg <= 1'b0;
            buf_rp_reg <= 1'b0;
            buf_cnt_reg <= 2'h0;
            ready_reg <= 1'b0;
            wr_ptr_reg <= 9'h000;
            base_reg <= 9'h000;
            fill_cnt_reg <= 9'h000;
            need_reg <= 9'(ssea_pkg::FIRST_FILL);
            valid_reg <= 1'b0;
            done_reg <= 1'b0;
            db_reg <= '0;
            rel_reg <= '0;
            bin_o_reg <= '0;
            ps_o_reg <= '0;
            band_o_reg <= '0;
            bwdet_reg <= 1'b0;
            dct_reg <= 1'b0;
            opbw_reg <= 2'h0;
        end else begin
            state_reg <= state_next;
            buf_wp_reg <= buf_wp_next;
            buf_rp_reg <= buf_rp_next;
            buf_cnt_reg <= buf_cnt_next;
            ready_reg <= ready_next;
            wr_ptr_reg <= wr_ptr_next;
            base_reg <= base_next;
            fill_cnt_reg <= fill_cnt_next;
            need_reg <= need_next;
            valid_reg <= valid_next;
            done_reg <= done_next;
            db_reg <= db_next;
            rel_reg <= rel_next;
            bin_o_reg <= bin_o_next;
            ps_o_reg <= ps_o_next;
            band_o_reg <= band_o_next;
            bwdet_reg <= bwdet_next;
            dct_reg <= dct_next;
            opbw_reg <= opbw_next;
        end
    end

    assign sample_ready_out = ready_reg;
    assign bin_energy_out = bin_o_reg;
    assign power_spectrum_out = ps_o_reg;
    assign band_avg_energy_out = band_o_reg;
    assign total_energy_db_out = db_reg;
    assign rel_energy_out = rel_reg;
    assign results_valid_out = valid_reg;
    assign done_out = done_reg;
    assign bw_detect_enable_out = bwdet_reg;
    assign detector_uses_dct_out = dct_reg;
    assign operating_bw_out = opbw_reg;
endmodule

// >>> core/ssea_pkg.sv
// Constants, tables and types of the speech spectral energy analyzer
package ssea_pkg;
    localparam int SAMPLE_W = 16;
    localparam int MEM_AW = 9;
    localparam int ACC_W = 26;
    localparam int MAG_W = 52;
    localparam int BSUM_W = 56;
    localparam int EN_W = 44;
    localparam int SUM_W = 48;
    localparam int DB_W = 18;
    localparam int FFT_LEN = 256;
    localparam int HALF_LEN = 128;
    localparam int FRAME_LEN = 256;
    localparam int CENTRE_FIRST = 96;
    localparam int CENTRE_STEP = 128;
    localparam int FIRST_FILL = FFT_LEN + CENTRE_STEP;
    localparam int NUM_BANDS = 20;
    localparam int BIN_SHIFT = 14;
    localparam int BAND_SHIFT = 14;
    localparam int RECIP_Q = 16;
    localparam int DB_SHIFT = 8;
    localparam logic [9:0] DB_PER_OCT = 10'h303;
    localparam logic [4:0] NB_FIRST_BAND = 5'h01;
    localparam logic [4:0] NB_LAST_BAND = 5'h10;
    localparam logic [7:0] LAST_BIN = 8'h80;
    localparam longint SIN_STEP_Q30 = 64'sh0000_0000_00c9_0e98;
    localparam longint SIN_RECUR_Q30 = 64'sh0000_0000_7ffd_885a;

    typedef logic signed [17:0] ssea_sin_tab_type [0:128];
    typedef logic [7:0] ssea_band_tab_type [0:20];
    typedef logic [16:0] ssea_recip_tab_type [0:19];

    typedef enum logic [1:0] {
        RATE_8K = 2'h0,
        RATE_16K = 2'h1,
        RATE_32K = 2'h2,
        RATE_48K = 2'h3
    } ssea_rate_type;

    typedef enum logic [1:0] {
        BW_NARROWBAND = 2'h0,
        BW_WIDEBAND = 2'h1,
        BW_SUPERWIDEBAND = 2'h2,
        BW_FULLBAND = 2'h3
    } ssea_bw_type;

    typedef enum logic [1:0] {
        ST_FILL = 2'b00,
        ST_MAC = 2'b01,
        ST_BIN = 2'b11,
        ST_FIN = 2'b10
    } ssea_state_type;

    // First bin of each band, plus the end marker one past band 19
    localparam ssea_band_tab_type BAND_START = '{
        8'h01, 8'h03, 8'h05, 8'h07, 8'h09, 8'h0b, 8'h0d, 8'h10,
        8'h13, 8'h16, 8'h1a, 8'h1e, 8'h23, 8'h29, 8'h2f, 8'h37,
        8'h40, 8'h4b, 8'h59, 8'h6b, 8'h80};

    // sin(pi*i/256) in Q15 by a Chebyshev recurrence, evaluated once
    function automatic ssea_sin_tab_type gen_sin();
        ssea_sin_tab_type t;
        longint a;
        longint b;
        longint c;
        a = 0;
        b = SIN_STEP_Q30;
        t[0] = 18'sh00000;
        for (int i = 1; i <= 128; i++) begin
            t[i] = 18'((b + 64'sh4000) >>> 15);
            c = ((SIN_RECUR_Q30 * b) >>> 30) - a;
            a = b;
            b = c;
        end
        return t;
    endfunction

    // Rounded Q16 reciprocal of each band's bin count
    function automatic ssea_recip_tab_type gen_recip();
        ssea_recip_tab_type t;
        int w;
        for (int i = 0; i < 20; i++) begin
            w = int'(BAND_START[i + 1]) - int'(BAND_START[i]);
            t[i] = 17'((32'h0001_0000 + w / 2) / w);
        end
        return t;
    endfunction

    localparam ssea_sin_tab_type SIN_TAB = gen_sin();
    localparam ssea_recip_tab_type RECIP = gen_recip();
endpackage

// >>> dv/speech_spectral_energy_analyzer_test.sv
// Self-checking bench: one narrowband frame through the analyzer
module speech_spectral_energy_analyzer_test;
    timeunit 1ns;
    timeprecision 100ps;
    localparam real PI = 3.14159265358979;
    logic clock_in, rst_in, slow, narrowband, legacy, s_valid, s_ready;
    logic valid, done, bw_en, dct;
    logic signed [ssea_pkg::SAMPLE_W-1:0] sample;
    logic signed [ssea_pkg::DB_W-1:0] lte, db, rel;
    logic [1:0] rate, det, opbw;
    logic [7:0] bin_sel;
    logic [5:0] band_sel;
    logic [ssea_pkg::EN_W-1:0] e_bin, ps, e_band;
    int n_fail, num_checks;
    real bin_ref [0:1][0:127];
    real band_ref [0:1][0:19];
    real db_ref;
    int start_bin [0:20] = '{1, 3, 5, 7, 9, 11, 13, 16, 19, 22, 26, 30, 35,
        41, 47, 55, 64, 75, 89, 107, 128};

    ssea_source src (.clock_in(clock_in), .rst_in(rst_in), .slow_in(slow),
        .ready_in(s_ready), .sample_out(sample), .valid_out(s_valid));
    ssea_core dut (.clock_in(clock_in), .rst_in(rst_in), .sample_in(sample),
        .sample_valid_in(s_valid), .sample_ready_out(s_ready),
        .narrowband_in(narrowband), .long_term_energy_in(lte),
        .input_rate_in(rate), .legacy_interop_mode_in(legacy),
        .detected_bw_in(det), .bin_sel_in(bin_sel), .band_sel_in(band_sel),
        .bin_energy_out(e_bin), .power_spectrum_out(ps),
        .band_avg_energy_out(e_band), .total_energy_db_out(db),
        .rel_energy_out(rel), .results_valid_out(valid), .done_out(done),
        .bw_detect_enable_out(bw_en), .detector_uses_dct_out(dct),
        .operating_bw_out(opbw));

    initial begin
        clock_in = 1'b0;
        forever #2.5 clock_in = ~clock_in;
    end

    task automatic step(input int n = 1);
        repeat (n) @(posedge clock_in);
        #1;
    endtask

    // Tolerance covers the core's fixed-point window and log approximation
    task automatic check(input string what, input logic [47:0] got,
        input real exp, input real tol);
        real g;
        g = real'($signed(got));
        num_checks++;
        if ((^got) === 1'bx || g > exp + tol || g < exp - tol) begin
            n_fail++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got,
                longint'(exp));
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic timed_out(input string what);
        n_fail++;
        $display("MISMATCH %0t timeout %s got %h exp %h", $time, what, 0, 1);
        close_out();
    endtask

    task automatic build_ref();
        real xr, xi, w, acc;
        real fr [0:1];
        for (int a = 0; a < 2; a++) begin
            fr[a] = 0.0;
            for (int k = 0; k < 128; k++) begin
                xr = 0.0;
                xi = 0.0;
                for (int n = 0; n < 256; n++) begin
                    w = $sin(PI * n / 256.0) * src.pre_tab[n + 128 * a];
                    xr += w * $cos(2.0 * PI * k * n / 256.0);
                    xi -= w * $sin(2.0 * PI * k * n / 256.0);
                end
                bin_ref[a][k] = (xr * xr + xi * xi) / 16384.0;
            end
            for (int i = 0; i < 20; i++) begin
                acc = 0.0;
                for (int k = start_bin[i]; k < start_bin[i + 1]; k++)
                    acc += bin_ref[a][k];
                acc = acc / (start_bin[i + 1] - start_bin[i]);
                band_ref[a][i] = (i >= 1 && i <= 16) ? acc : 0.0;
                fr[a] += band_ref[a][i];
            end
        end
        db_ref = 2560.0 * $log10(0.5 * (fr[0] + fr[1]));
    endtask

    task automatic test_bandwidth();
        logic [1:0] exp_bw;
        for (int r = 0; r < 4; r++) begin
            for (int d = 0; d < 4; d++) begin
                rate = 2'(r);
                det = 2'(d);
                legacy = 1'(d % 2);
                step();
                exp_bw = (r == 0) ? 2'h0 : (d < r ? 2'(d) : 2'(r));
                check("bw enable", {47'h0, bw_en}, r != 0, 0.5);
                check("dct source", {47'h0, dct}, d % 2, 0.5);
                check("op class", {46'h0, opbw}, exp_bw, 0.5);
            end
        end
        $display("test_bandwidth done");
    endtask

    // Samples past the frame fill the two-entry buffer, then are refused
    task automatic test_stream();
        int t = 0;
        while (src.idx < 384 && t < 5000) begin
            if (src.idx >= 200)
                slow = 1'b0;
            step();
            t++;
        end
        if (t == 5000)
            timed_out("frame fill");
        step(30);
        check("taken while busy", src.idx, 386.0, 0.5);
        check("ready while busy", {47'h0, s_ready}, 0.0, 0.5);
        $display("test_stream done");
    endtask

    task automatic test_results();
        int t = 0;
        while (done !== 1'b1 && t < 70000) begin
            step();
            t++;
        end
        if (t == 70000)
            timed_out("done");
        check("valid at done", {47'h0, valid}, 1.0, 0.5);
        check("total db", {{30{db[17]}}, db}, db_ref, 100.0);
        check("rel db", {{30{rel[17]}}, rel}, db_ref - 2560.0, 100.0);
        step();
        check("done pulse", {47'h0, done}, 0.0, 0.5);
        step(40);
        check("buffer drained", src.idx, 400.0, 0.5);
        $display("test_results done");
    endtask

    task automatic test_bins();
        real e;
        for (int a = 0; a < 2; a++) begin
            for (int k = 0; k < 128; k++) begin
                bin_sel = {1'(a), 7'(k)};
                step();
                e = bin_ref[a][k];
                check("bin energy", {4'h0, e_bin}, e, e / 25.0 + 32.0);
                e = 0.5 * (bin_ref[0][k] + bin_ref[1][k]);
                check("power spec", {4'h0, ps}, e, e / 25.0 + 32.0);
            end
        end
        $display("test_bins done");
    endtask

    task automatic test_bands();
        real e;
        for (int s = 0; s < 41; s++) begin
            band_sel = 6'(s);
            step();
            e = (s < 40) ? band_ref[s / 20][s % 20] : 0.0;
            check("band energy", {4'h0, e_band}, e, e / 25.0 + 1.0);
        end
        $display("test_bands done");
    endtask

    initial begin
        rst_in = 1'b1;
        slow = 1'b1;
        narrowband = 1'b1;
        lte = 18'sh00a00;
        rate = 2'h0;
        det = 2'h0;
        legacy = 1'b0;
        bin_sel = 8'h00;
        band_sel = 6'h00;
        n_fail = 0;
        num_checks = 0;
        step(2);
        check("ready in reset", {47'h0, s_ready}, 0.0, 0.5);
        check("valid in reset", {47'h0, valid}, 0.0, 0.5);
        rst_in = 1'b0;
        build_ref();
        test_bandwidth();
        test_stream();
        test_results();
        test_bins();
        test_bands();
        close_out();
    end
endmodule

// >>> dv/ssea_core_sva.sv
// Concurrent checks on the analyzer's ports, bound into the core
module ssea_core_check (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic sample_valid_in,
    input wire logic sample_ready_out,
    input wire logic narrowband_in,
    input wire logic signed [ssea_pkg::DB_W-1:0] long_term_energy_in,
    input wire logic [1:0] input_rate_in,
    input wire logic legacy_interop_mode_in,
    input wire logic [1:0] detected_bw_in,
    input wire logic [5:0] band_sel_in,
    input wire logic [ssea_pkg::EN_W-1:0] bin_energy_out,
    input wire logic [ssea_pkg::EN_W-1:0] power_spectrum_out,
    input wire logic [ssea_pkg::EN_W-1:0] band_avg_energy_out,
    input wire logic signed [ssea_pkg::DB_W-1:0] total_energy_db_out,
    input wire logic signed [ssea_pkg::DB_W-1:0] rel_energy_out,
    input wire logic results_valid_out,
    input wire logic done_out,
    input wire logic bw_detect_enable_out,
    input wire logic detector_uses_dct_out,
    input wire logic [1:0] operating_bw_out
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);

    property p_reset_clear;
        $fell(rst_in) |-> !sample_ready_out && !done_out && !results_valid_out;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("outputs not clear after reset");
    property p_done_pulse; done_out |=> !done_out; endproperty
    a_done_pulse: assert property (p_done_pulse)
        else $error("done longer than one cycle");
    property p_done_valid; done_out |-> $rose(results_valid_out); endproperty
    a_done_valid: assert property (p_done_valid)
        else $error("results valid not raised with done");
    property p_rel;
        done_out |-> rel_energy_out
            == total_energy_db_out - long_term_energy_in;
    endproperty
    a_rel: assert property (p_rel)
        else $error("relative energy not total minus long term");
    property p_bw_enable;
        !$past(rst_in) |-> bw_detect_enable_out == (|$past(input_rate_in));
    endproperty
    a_bw_enable: assert property (p_bw_enable)
        else $error("detector enable wrong for input rate");
    property p_dct;
        !$past(rst_in)
            |-> detector_uses_dct_out == $past(legacy_interop_mode_in);
    endproperty
    a_dct: assert property (p_dct)
        else $error("detector source wrong");
    property p_opbw;
        !$past(rst_in) |-> operating_bw_out == (($past(input_rate_in) == 2'h0)
            ? 2'h0 : ($past(detected_bw_in) < $past(input_rate_in))
            ? $past(detected_bw_in) : $past(input_rate_in));
    endproperty
    a_opbw: assert property (p_opbw)
        else $error("operating class wrong");
    // A take one edge back may still fill the buffer, so skip that case
    property p_ready_keep;
        sample_ready_out && !sample_valid_in
            && !$past(sample_valid_in && sample_ready_out) |=> sample_ready_out;
    endproperty
    a_ready_keep: assert property (p_ready_keep)
        else $error("ready dropped without a take");
    property p_idle_reads;
        !results_valid_out |-> bin_energy_out == '0
            && power_spectrum_out == '0 && band_avg_energy_out == '0;
    endproperty
    a_idle_reads: assert property (p_idle_reads)
        else $error("result reads not zero without results");
    property p_nb_bands;
        narrowband_in && band_sel_in inside {6'h00, 6'h11, 6'h12, 6'h13, 6'h14,
            6'h25, 6'h26, 6'h27} |=> band_avg_energy_out == '0;
    endproperty
    a_nb_bands: assert property (p_nb_bands)
        else $error("excluded narrowband band not zero");

    c_done: cover property (done_out);
    c_refused: cover property (sample_valid_in && !sample_ready_out);
    c_nb_read: cover property (results_valid_out && band_sel_in == 6'h00);
endmodule

bind ssea_core ssea_core_check u_check (.*);

// >>> dv/ssea_source.sv
// Upstream emphasis stage model feeding the analyzer's sample stream
module ssea_source (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic slow_in,
    input wire logic ready_in,
    output logic signed [ssea_pkg::SAMPLE_W-1:0] sample_out,
    output logic valid_out
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam real PI = 3.14159265358979;
    logic signed [ssea_pkg::SAMPLE_W-1:0] pre_tab [0:399];
    int idx, gap;

    initial begin
        real raw, prev;
        prev = 0.0;
        idx = 0;
        gap = 0;
        valid_out = 1'b0;
        sample_out = '0;
        for (int n = 0; n < 400; n++) begin
            raw = 4000.0 * ($cos(2.0 * PI * 1.5 * n / 256.0)
                + $cos(2.0 * PI * 30.0 * n / 256.0)
                + $cos(2.0 * PI * 100.0 * n / 256.0));
            pre_tab[n] = 16'($rtoi(raw - 0.68 * prev));
            prev = raw;
        end
        forever begin
            @(posedge clock_in);
            if (valid_out === 1'b1 && ready_in === 1'b1) begin
                idx++;
                gap = slow_in ? 2 : 0;
            end
            #1;
            if (rst_in || idx >= 400 || gap > 0) begin
                valid_out = 1'b0;
                // Idle data toggles so a stale word never looks fresh
                sample_out = ~sample_out;
                gap = gap > 0 ? gap - 1 : 0;
            end else begin
                valid_out = 1'b1;
                sample_out = pre_tab[idx];
            end
        end
    end
endmodule
